// ---- rtl/adhcp_pkg.sv ----
// Purpose: Shared constants and types of the audio DSP host command port.
// Assumes: Command codes double as the register offsets.
// Notes:   Reset values of unused words are zero.
package adhcp_pkg;

    localparam logic [7:0] BUS_ADDRESS    = 8'h32;
    localparam logic [3:0] CMD_GROUP      = 4'h4;

    localparam logic [7:0] CMD_TIMING     = 8'h40;
    localparam logic [7:0] CMD_BOOT       = 8'h41;
    localparam logic [7:0] CMD_INPUT      = 8'h42;
    localparam logic [7:0] CMD_OUTPUT     = 8'h43;
    localparam logic [7:0] CMD_RUN_MUTE   = 8'h44;
    localparam logic [7:0] CMD_SEQ_RAM    = 8'h45;
    localparam logic [7:0] CMD_COEF_RAM   = 8'h46;
    localparam logic [7:0] CMD_COEF_BATCH = 8'h47;
    localparam logic [7:0] CMD_OFFS_RAM   = 8'h48;
    localparam logic [7:0] CMD_OFFS_BATCH = 8'h49;
    localparam logic [7:0] CMD_BUF_FLAG   = 8'h4A;
    localparam logic [7:0] CMD_DEEMPH     = 8'h4B;
    localparam logic [7:0] CMD_TRIM_FRONT = 8'h4C;
    localparam logic [7:0] CMD_TRIM_CS    = 8'h4D;
    localparam logic [7:0] CMD_FILTER_ATT = 8'h4E;
    localparam logic [7:0] CMD_INIT       = 8'h4F;

    localparam logic [15:0] RST_TIMING    = 16'h4400;
    localparam logic [15:0] RST_BOOT      = 16'h0000;
    localparam logic [15:0] RST_INPUT     = 16'h0100;
    localparam logic [15:0] RST_OUTPUT    = 16'h0080;
    localparam logic [15:0] RST_RUN_MUTE  = 16'h1F0F;
    localparam logic [15:0] RST_OTHER     = 16'h0000;

    localparam int RUN_BIT                = 15;
    localparam int BOOT_MSB               = 8;
    localparam int BATCH_DEPTH            = 32;
    localparam int RAM_ADDR_W             = 9;

    typedef enum logic [1:0] {
        RAM_SEQUENCE    = 2'h0,
        RAM_COEFFICIENT = 2'h1,
        RAM_OFFSET      = 2'h2
    } adhcp_ram_t;

    typedef struct packed {
        logic [15:0] timing_config;
        logic [15:0] boot_start_address;
        logic [15:0] input_config;
        logic [15:0] output_config;
        logic [15:0] run_and_mute_control;
        logic [15:0] buffer_flag_setting;
        logic [15:0] deemphasis_setting;
        logic [15:0] dac_trim_front;
        logic [15:0] dac_trim_center_surround;
        logic [15:0] filter_attenuation;
    } adhcp_cfg_t;

    typedef struct packed {
        logic       program_start_edge;
        logic [1:0] program_sync_source;
        logic       filter_start_edge;
        logic [1:0] filter_sync_source;
        logic       reference_left_level;
        logic [1:0] reference_source;
        logic       lr_output_rate;
        logic [1:0] bitclk_output_rate;
    } adhcp_timing_t;

    typedef struct packed {
        logic [1:0] input_routing;
        logic       input_threshold_sel;
        logic       analog_auto_mute;
        logic [3:0] analog_input_mask;
        logic       zero_level_mute;
        logic       serial_in_role;
        logic [1:0] input_slot_count;
        logic [1:0] input_word_length;
        logic [1:0] input_justification;
    } adhcp_input_t;

    typedef struct packed {
        logic                  valid;
        adhcp_ram_t            target;
        logic [RAM_ADDR_W-1:0] addr;
        logic [15:0]           data;
    } adhcp_ram_wr_t;

endpackage

// ---- rtl/adhcp_command_port.sv ----
// Purpose: Two-wire bus command port that loads control words and RAMs.
// Assumes: Pins are asynchronous; fs_sync is a one-cycle pulse on clock.
// Notes:   Write only; the data line is driven low only for acknowledge.
// Overview of operation
// - Bus mode only while mode pin high.
// - Accept control only while select low.
// - Sample data on serial clock rising edge.
// - Ignore clock and data while select high.
// - Bus address 32h, then command byte.
// - Two data bytes MSB first form word.
// - Synchronous commands apply at sample sync.
// - RAM: address pair, data, auto increment.
// - Running: one RAM word per sync.
// - Batch words buffered, copied together at sync.
// - Decode command codes 40h to 4Fh.
// - Timing program edge and sync source.
// - Timing filter edge and sync source.
// - Timing reference level and source.
// - Timing LR and bit clock rates.
// - Boot address write starts self-boot.
// - Input routing and serial role.
// - Input slots, word length, justification.
// - Input thresholds, auto-mute, analog mask, zero-mute.
`timescale 1ns/1ps
`default_nettype none

module adhcp_command_port #(
    parameter int BUF_DEPTH = adhcp_pkg::BATCH_DEPTH
) (
    input  wire logic                    clock,
    input  wire logic                    rstn,
    input  wire logic                    bus_mode_select_pin,
    input  wire logic                    host_select_n,
    input  wire logic                    host_serial_clock,
    input  wire logic                    host_serial_data,
    output logic                         host_serial_data_out,
    output logic                         host_serial_data_oe_n,
    input  wire logic                    fs_sync,
    output adhcp_pkg::adhcp_cfg_t        cfg,
    output adhcp_pkg::adhcp_timing_t     timing_fields,
    output adhcp_pkg::adhcp_input_t      input_fields,
    output logic [8:0]                   boot_rom_start,
    output logic                         boot_start,
    output logic                         init_pulse,
    output adhcp_pkg::adhcp_ram_wr_t     ram_wr,
    output logic                         batch_busy
);

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ADDR = 5'b00010,
        ST_CMD  = 5'b00100,
        ST_DATA = 5'b01000,
        ST_SKIP = 5'b10000
    } adhcp_state_t;

    localparam int IDX_W = $clog2(BUF_DEPTH + 1);
    localparam adhcp_pkg::adhcp_cfg_t CFG_RESET = {adhcp_pkg::RST_TIMING,
        adhcp_pkg::RST_BOOT, adhcp_pkg::RST_INPUT, adhcp_pkg::RST_OUTPUT,
        adhcp_pkg::RST_RUN_MUTE, {5{adhcp_pkg::RST_OTHER}}};

    // Pin synchronisers: stage one is read only by stage two.
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic       scl_d;
    logic       sda_d;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pin_s1 <= 4'h3;
            pin_s2 <= 4'h3;            // Lines idle high: no false edge.
            scl_d  <= 1'b1;
            sda_d  <= 1'b1;
        end else begin
            pin_s1 <= {bus_mode_select_pin, host_select_n,
                       host_serial_clock, host_serial_data};
            pin_s2 <= pin_s1;
            scl_d  <= pin_s2[1];
            sda_d  <= pin_s2[0];
        end
    end

    wire logic scl        = pin_s2[1];
    wire logic sda        = pin_s2[0];
    wire logic active     = pin_s2[3] && !pin_s2[2];
    wire logic scl_rise   = active && scl && !scl_d;
    wire logic scl_fall   = active && !scl && scl_d;
    wire logic start_cond = active && scl && scl_d && sda_d && !sda;
    wire logic stop_cond  = active && scl && scl_d && !sda_d && sda;

    // Bit level: shift on rising edges, acknowledge on the ninth clock.
    adhcp_state_t state;
    logic [3:0]   bit_cnt;
    logic [6:0]   shift;
    logic         byte_done;
    logic [7:0]   byte_val;
    logic         ack_want;
    logic         ack_pend;
    logic         ack_drive;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bit_cnt   <= 4'h0;
            shift     <= 7'h00;
            byte_done <= 1'b0;
            byte_val  <= 8'h00;
        end else begin
            byte_done <= 1'b0;
            if (start_cond || !active) begin
                bit_cnt <= 4'h0;
            end else if (scl_rise && state != ST_IDLE) begin
                bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
                if (bit_cnt == 4'h7) begin
                    byte_done <= 1'b1;
                    byte_val  <= {shift, sda};
                end else if (bit_cnt < 4'h7) begin
                    shift <= {shift[5:0], sda};
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ack_pend  <= 1'b0;
            ack_drive <= 1'b0;
        end else if (!active || start_cond || stop_cond) begin
            ack_pend  <= 1'b0;
            ack_drive <= 1'b0;
        end else begin
            if (ack_want) begin
                ack_pend <= 1'b1;
            end else if (scl_fall && ack_pend && bit_cnt == 4'h8) begin
                ack_pend  <= 1'b0;
                ack_drive <= 1'b1;
            end
            if (scl_fall && ack_drive && bit_cnt == 4'h0) begin
                ack_drive <= 1'b0;
            end
        end
    end

    assign host_serial_data_out  = 1'b0;
    assign host_serial_data_oe_n = !ack_drive;

    // Byte level: address, command, then data words in pairs.
    logic [7:0]  cmd;
    logic        half;
    logic [7:0]  hi_byte;
    logic        word_done;
    logic [15:0] word;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state     <= ST_IDLE;
            cmd       <= 8'h00;
            half      <= 1'b0;
            hi_byte   <= 8'h00;
            word_done <= 1'b0;
            word      <= 16'h0000;
            ack_want  <= 1'b0;
        end else begin
            word_done <= 1'b0;
            ack_want  <= 1'b0;
            if (!active || stop_cond) begin
                state <= ST_IDLE;
            end else if (start_cond) begin
                state <= ST_ADDR;
            end else if (byte_done) begin
                unique case (state)
                    ST_ADDR: begin
                        if (byte_val == adhcp_pkg::BUS_ADDRESS) begin
                            state    <= ST_CMD;
                            ack_want <= 1'b1;
                        end else begin
                            state <= ST_SKIP;
                        end
                    end
                    ST_CMD: begin
                        if (byte_val[7:4] == adhcp_pkg::CMD_GROUP) begin
                            cmd      <= byte_val;
                            half     <= 1'b0;
                            state    <= ST_DATA;
                            ack_want <= 1'b1;
                        end else begin
                            state <= ST_SKIP;
                        end
                    end
                    ST_DATA: begin
                        ack_want <= 1'b1;
                        half     <= !half;
                        if (!half) begin
                            hi_byte <= byte_val;
                        end else begin
                            word      <= {hi_byte, byte_val};
                            word_done <= 1'b1;
                        end
                    end
                    ST_IDLE, ST_SKIP: ;
                endcase
            end
        end
    end

    // Command class decode.
    wire logic is_ram   = cmd >= adhcp_pkg::CMD_SEQ_RAM &&
                          cmd <= adhcp_pkg::CMD_OFFS_BATCH;
    wire logic is_batch = cmd == adhcp_pkg::CMD_COEF_BATCH ||
                          cmd == adhcp_pkg::CMD_OFFS_BATCH;
    wire logic is_sync  = cmd == adhcp_pkg::CMD_RUN_MUTE ||
                          (cmd >= adhcp_pkg::CMD_BUF_FLAG &&
                           cmd <= adhcp_pkg::CMD_TRIM_CS);
    adhcp_pkg::adhcp_ram_t cmd_target;

    always_comb begin
        if (cmd == adhcp_pkg::CMD_SEQ_RAM) begin
            cmd_target = adhcp_pkg::RAM_SEQUENCE;
        end else if (cmd == adhcp_pkg::CMD_COEF_RAM ||
                     cmd == adhcp_pkg::CMD_COEF_BATCH) begin
            cmd_target = adhcp_pkg::RAM_COEFFICIENT;
        end else begin
            cmd_target = adhcp_pkg::RAM_OFFSET;
        end
    end

    wire logic running = cfg.run_and_mute_control[adhcp_pkg::RUN_BIT];

    // Control words; synchronous ones wait in a pending slot for fs_sync.
    logic        sync_pend;
    logic [7:0]  sync_cmd;
    logic [15:0] sync_word;
    wire logic   reg_wr   = word_done && !is_ram;
    wire logic   init_now = reg_wr && cmd == adhcp_pkg::CMD_INIT;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cfg        <= CFG_RESET;
            sync_pend  <= 1'b0;
            sync_cmd   <= 8'h00;
            sync_word  <= 16'h0000;
            boot_start <= 1'b0;
            init_pulse <= 1'b0;
        end else begin
            boot_start <= 1'b0;
            init_pulse <= 1'b0;
            if (fs_sync && sync_pend) begin
                sync_pend <= 1'b0;
                unique case (sync_cmd)
                    adhcp_pkg::CMD_RUN_MUTE:
                        cfg.run_and_mute_control <= sync_word;
                    adhcp_pkg::CMD_BUF_FLAG:
                        cfg.buffer_flag_setting <= sync_word;
                    adhcp_pkg::CMD_DEEMPH:
                        cfg.deemphasis_setting <= sync_word;
                    adhcp_pkg::CMD_TRIM_FRONT:
                        cfg.dac_trim_front <= sync_word;
                    default:
                        cfg.dac_trim_center_surround <= sync_word;
                endcase
            end
            if (init_now) begin
                cfg        <= CFG_RESET;
                sync_pend  <= 1'b0;
                init_pulse <= 1'b1;
            end else if (reg_wr && is_sync) begin
                sync_pend <= 1'b1;
                sync_cmd  <= cmd;
                sync_word <= word;
            end else if (reg_wr) begin
                unique case (cmd)
                    adhcp_pkg::CMD_TIMING:
                        cfg.timing_config <= word;
                    adhcp_pkg::CMD_BOOT: begin
                        cfg.boot_start_address <= word;
                        boot_start <= 1'b1;
                    end
                    adhcp_pkg::CMD_INPUT:
                        cfg.input_config <= word;
                    adhcp_pkg::CMD_OUTPUT:
                        cfg.output_config <= word;
                    default:
                        cfg.filter_attenuation <= word;
                endcase
            end
        end
    end

    // Field views of the timing and input words.
    assign timing_fields = {cfg.timing_config[14:12],
                            cfg.timing_config[10:8],
                            cfg.timing_config[6:4],
                            cfg.timing_config[2:0]};
    assign input_fields  = cfg.input_config;

    assign boot_rom_start = cfg.boot_start_address[adhcp_pkg::BOOT_MSB:0];

    // RAM streaming: address pair first, then words at rising addresses.
    logic                            have_addr;
    logic [adhcp_pkg::RAM_ADDR_W-1:0] ram_ptr;
    adhcp_pkg::adhcp_ram_t           ram_tgt;
    logic                            direct_pend;
    logic [15:0]                     direct_data;
    logic                            collecting;
    logic                            armed;
    logic                            copying;
    logic [IDX_W-1:0]                buf_cnt;
    logic [IDX_W-1:0]                copy_idx;
    logic [15:0]                     batch_buffer_ram [BUF_DEPTH];
    logic                            buf_wr;

    assign buf_wr = word_done && is_ram && is_batch && have_addr &&
                    buf_cnt < IDX_W'(BUF_DEPTH);

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            have_addr  <= 1'b0;
            ram_ptr    <= '0;
            ram_tgt    <= adhcp_pkg::RAM_SEQUENCE;
            collecting <= 1'b0;
            armed      <= 1'b0;
            buf_cnt    <= '0;
        end else begin
            if (byte_done && state == ST_CMD) begin
                have_addr <= 1'b0;
            end
            if (init_now) begin
                collecting <= 1'b0;
                armed      <= 1'b0;
            end else if (word_done && is_ram && !have_addr) begin
                have_addr  <= 1'b1;
                ram_ptr    <= word[adhcp_pkg::RAM_ADDR_W-1:0];
                ram_tgt    <= cmd_target;
                collecting <= is_batch;
                buf_cnt    <= '0;
            end else if (word_done && is_ram && !is_batch) begin
                ram_ptr <= ram_ptr + 1'b1;
            end else if (buf_wr) begin
                buf_cnt <= buf_cnt + 1'b1;
            end
            if (collecting && state == ST_IDLE) begin
                collecting <= 1'b0;
                armed      <= buf_cnt != '0;
            end
            if (armed && fs_sync) begin
                armed <= 1'b0;
            end
        end
    end

    generate
        for (genvar i = 0; i < BUF_DEPTH; i++) begin : g_buf
            always_ff @(posedge clock) begin
                if (buf_wr && buf_cnt == IDX_W'(i)) begin
                    batch_buffer_ram[i] <= word;
                end
            end
        end
    endgenerate

    // Write port: batch copy first, then direct words (per sync if running).
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ram_wr      <= '0;
            direct_pend <= 1'b0;
            direct_data <= 16'h0000;
            copying     <= 1'b0;
            copy_idx    <= '0;
        end else begin
            ram_wr.valid <= 1'b0;
            if (word_done && is_ram && !is_batch && have_addr) begin
                direct_pend <= 1'b1;
                direct_data <= word;
                ram_wr.addr <= ram_ptr;
            end
            if (armed && fs_sync) begin
                copying  <= 1'b1;
                copy_idx <= '0;
            end else if (copying) begin
                ram_wr.valid  <= 1'b1;
                ram_wr.target <= ram_tgt;
                ram_wr.addr   <= ram_ptr + adhcp_pkg::RAM_ADDR_W'(copy_idx);
                ram_wr.data   <= batch_buffer_ram[copy_idx[$clog2(
                    BUF_DEPTH)-1:0]];
                copy_idx      <= copy_idx + 1'b1;
                if (copy_idx + 1'b1 == buf_cnt) begin
                    copying <= 1'b0;
                end
            end else if (direct_pend && (!running || fs_sync)) begin
                direct_pend   <= 1'b0;
                ram_wr.valid  <= 1'b1;
                ram_wr.target <= ram_tgt;
                ram_wr.data   <= direct_data;
            end
        end
    end

    assign batch_busy = collecting || armed || copying;

endmodule

`default_nettype wire

// ---- bench/adhcp_checker_assertions.sv ----
// Purpose: Assertions on the command port outputs.
// Assumes: One clock; pins reach the logic a few cycles late.
// Notes:   Margins cover the pin synchronisers.
`timescale 1ns/1ps
`default_nettype none
module adhcp_checker (
    input wire logic                     clock,
    input wire logic                     rstn,
    input wire logic                     host_select_n,
    input wire logic                     host_serial_data_oe_n,
    input wire logic                     fs_sync,
    input wire adhcp_pkg::adhcp_cfg_t    cfg,
    input wire adhcp_pkg::adhcp_timing_t timing_fields,
    input wire adhcp_pkg::adhcp_input_t  input_fields,
    input wire logic [8:0]               boot_rom_start,
    input wire logic                     boot_start,
    input wire logic                     init_pulse
);
    wire logic [15:0] tc = cfg.timing_config;
    wire logic [15:0] rmc = cfg.run_and_mute_control;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence deselected; host_select_n [*6]; endsequence
    a_sel_quiet: assert property (deselected |-> host_serial_data_oe_n)
        else $error("ack while deselected");
    a_sync_apply: assert property ($changed(rmc) |->
        ($past(fs_sync) || $past(init_pulse)) or ##[0:1] init_pulse)
        else $error("sync word applied off the sample sync");
    a_boot_once: assert property (boot_start |=> !boot_start)
        else $error("boot start too long");
    a_boot_field: assert property (
        boot_rom_start == cfg.boot_start_address[8:0])
        else $error("boot address view wrong");
    a_init_defaults: assert property (init_pulse |-> ##[0:2]
        (tc == 16'h4400))
        else $error("init left timing word");
    a_init_once: assert property (init_pulse |=> !init_pulse)
        else $error("init pulse too long");
    a_timing_view: assert property (timing_fields ==
        {tc[14:12], tc[10:8], tc[6:4], tc[2:0]})
        else $error("timing fields wrong");
    a_input_view: assert property (input_fields == cfg.input_config)
        else $error("input fields wrong");
endmodule
`default_nettype wire

// ---- bench/adhcp_host_model.sv ----
// Purpose: Two-wire bus host model sending write frames.
// Assumes: Lines idle high; clock phases last several cycles.
// Notes:   Write frames only; a missing ack is counted.
`timescale 1ns/1ps
`default_nettype none
module adhcp_host_model (
    input  wire logic clock,
    input  wire logic sda_in,
    output var logic  scl = 1'b1,
    output var logic  sda = 1'b1
);
    int nacks = 0;
    task automatic wt(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // Data moves two cycles after the fall, clear of the synchronisers.
    task automatic put(input logic [7:0] b);
        for (int i = 7; i >= -1; i--) begin
            sda = (i < 0) ? 1'b1 : b[i & 7];
            wt(3);
            scl = 1'b1;
            wt(5);
            if (i < 0 && sda_in !== 1'b0) nacks++;
            scl = 1'b0;
            wt(2);
        end
    endtask
    task automatic frame(input logic [7:0] q[$]);
        sda = 1'b0;
        wt(5);
        scl = 1'b0;
        wt(2);
        put(8'h32);
        foreach (q[i]) put(q[i]);
        sda = 1'b0;
        wt(3);
        scl = 1'b1;
        wt(5);
        sda = 1'b1;
        wt(5);
    endtask
endmodule
`default_nettype wire

// ---- bench/audio_dsp_host_command_port_bench.sv ----
// Purpose: Self-checking bench for the command port.
// Assumes: The host model drives the bus; the bench pulses fs_sync.
// Notes:   Sample periods are shortened to a few dozen cycles.
`timescale 1ns/1ps
`default_nettype none
module audio_dsp_host_command_port_bench;
    logic clock = 1'b0, rstn = 1'b0, fs_sync = 1'b0, sda_drv;
    logic bus_mode_select_pin = 1'b1, host_select_n = 1'b0;
    logic host_serial_clock, host_serial_data_out, host_serial_data_oe_n;
    logic boot_start, init_pulse, batch_busy;
    logic [8:0] boot_rom_start;
    adhcp_pkg::adhcp_cfg_t    cfg;
    adhcp_pkg::adhcp_timing_t timing_fields;
    adhcp_pkg::adhcp_input_t  input_fields;
    adhcp_pkg::adhcp_ram_wr_t ram_wr, log[$];
    int n_errors = 0, num_checks = 0, cycles = 0, boots = 0;
    wire logic host_serial_data = sda_drv &
        (host_serial_data_oe_n | host_serial_data_out);
    adhcp_command_port uut (.clock, .rstn, .bus_mode_select_pin,
        .host_select_n, .host_serial_clock, .host_serial_data,
        .host_serial_data_out, .host_serial_data_oe_n, .fs_sync, .cfg,
        .timing_fields, .input_fields, .boot_rom_start, .boot_start,
        .init_pulse, .ram_wr, .batch_busy);
    adhcp_host_model host (.clock, .sda_in(host_serial_data),
        .scl(host_serial_clock), .sda(sda_drv));
    initial forever #5 clock = ~clock;
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (ram_wr.valid === 1'b1) log.push_back(ram_wr);
        if (boot_start === 1'b1) boots++;
        if (cycles == 60000) begin
            n_errors++;
            report_and_stop();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] w);
        host.frame('{c, w[15:8], w[7:0]});
        step(10);
    endtask
    task automatic fs();
        host_select_n = 1'b1;
        step(20);
        fs_sync = 1'b1;
        step(1);
        fs_sync = 1'b0;
        step(20);
        host_select_n = 1'b0;
        step(5);
    endtask
    task automatic t_regs();
        chk("timing", cfg.timing_config, 16'h4400);
        chk("input", cfg.input_config, 16'h0100);
        wr(8'h40, 16'h5215);
        chk("timing_fields", timing_fields, 16'h0A8D);
        wr(8'h42, 16'hF3C6);
        chk("input_fields", input_fields, 16'hF3C6);
        wr(8'h41, 16'h01FE);
        chk("boot_rom_start", boot_rom_start, 16'h01FE);
        chk("boot_start", boots, 1);
        chk("nacks", host.nacks, 0);
        $display("register test done");
    endtask
    task automatic t_sync();
        wr(8'h44, 16'h0000);
        chk("run_mute held", cfg.run_and_mute_control, 16'h1F0F);
        fs();
        chk("run_mute", cfg.run_and_mute_control, 16'h0000);
        $display("sync test done");
    endtask
    task automatic t_ram();
        logic [7:0] code [3] = '{8'h45, 8'h46, 8'h48};
        for (int k = 0; k < 3; k++) begin
            log.delete();
            host.frame('{code[k], 8'h00, 8'h05, 8'h12, 8'h34, 8'hAB, 8'hCD});
            step(10);
            chk("commits", log.size(), 2);
            chk("addr", log[1].addr, 16'h0006);
            chk("target", log[0].target, k);
        end
        $display("ram test done");
    endtask
    task automatic t_batch();
        log.delete();
        host.frame('{8'h47, 8'h00, 8'h10, 8'h11, 8'h11, 8'h33, 8'h33});
        step(10);
        chk("early commits", log.size(), 0);
        chk("batch_busy", batch_busy, 1);
        fs();
        chk("batch data", log[1].data, 16'h3333);
        chk("batch addr", log[1].addr, 16'h0011);
        $display("batch test done");
    endtask
    task automatic t_refuse();
        int n0 = host.nacks;
        wr(8'h50, 16'h1234);
        chk("bad command", host.nacks > n0, 1);
        host_select_n = 1'b1;
        wr(8'h40, 16'h0000);
        bus_mode_select_pin = 1'b0;
        host_select_n = 1'b0;
        wr(8'h40, 16'h0000);
        bus_mode_select_pin = 1'b1;
        step(5);
        chk("timing kept", cfg.timing_config, 16'h5215);
        wr(8'h4F, 16'h0000);
        chk("timing init", cfg.timing_config, 16'h4400);
        $display("refusal test done");
    endtask
    initial begin
        step(5);
        rstn = 1'b1;
        step(5);
        t_regs();
        t_sync();
        t_ram();
        t_batch();
        t_refuse();
        report_and_stop();
    end
endmodule
bind adhcp_command_port adhcp_checker chk_i (.clock, .rstn, .host_select_n,
    .host_serial_data_oe_n, .fs_sync, .cfg, .timing_fields, .input_fields,
    .boot_rom_start, .boot_start, .init_pulse);
`default_nettype wire
